// >>> logic/dscg_consts.vh
`ifndef DSCG_CONSTS_VH
`define DSCG_CONSTS_VH

// System control block base address and register offsets.
`define DSCG_BASE_ADDR        32'h400F_E000
`define DSCG_BASE_HI_MSB      31
`define DSCG_BASE_HI_LSB      12
`define DSCG_OFS_INT_STATUS   12'h050
`define DSCG_OFS_INT_MASK     12'h054
`define DSCG_OFS_RUN_CFG      12'h060
`define DSCG_OFS_RUN_GATE     12'h100
`define DSCG_OFS_SLEEP_GATE   12'h110
`define DSCG_OFS_DEEP_GATE    12'h124

// Reset values.
`define DSCG_GATE_RESET       32'h0000_0000
`define DSCG_CFG_RESET        32'h0000_0000
`define DSCG_INT_RESET        32'h0000_0000

// Writable enables of the gating registers; all else is reserved.
`define DSCG_GATE_WMASK       32'h070F_1117

// Gating register field positions.
`define DSCG_BIT_COMPARATOR_2_GATE        26
`define DSCG_BIT_COMPARATOR_1_GATE        25
`define DSCG_BIT_COMPARATOR_0_GATE        24
`define DSCG_BIT_GP_TIMER_3_GATE       19
`define DSCG_BIT_GP_TIMER_0_GATE       16
`define DSCG_BIT_TWO_WIRE0    12
`define DSCG_BIT_QUAD_ENC0    8
`define DSCG_BIT_SYNC_SER0    4
`define DSCG_BIT_ASYNC_SER2   2
`define DSCG_BIT_ASYNC_SER0   0

// Run-mode configuration: automatic clock gating select bit.
`define DSCG_BIT_AUTO_SEL     0

// Interrupt status layout.
`define DSCG_INT_W            3
`define DSCG_INT_FAULT        0
`define DSCG_INT_DEEP_ENTER   1
`define DSCG_INT_DEEP_EXIT    2
`define DSCG_INT_WMASK        32'h0000_0007

`endif

// >>> logic/dscg_pin_sync.v
// Three-stage synchroniser for a pin level.  The output only moves when
// the second and third stages agree, so a level must hold two clocks.
module dscg_pin_sync (
    pclk,
    presetn,
    pin_in,
    level_r
);
    input  wire pclk;
    input  wire presetn;
    input  wire pin_in;
    output reg  level_r;

    reg         meta_r;
    reg         s2_r;
    reg         s3_r;

    // The first stage feeds only the second stage.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r  <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_r <= 1'b0;
        end else begin
            meta_r <= pin_in;
            s2_r   <= meta_r;
            s3_r   <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end
endmodule

// >>> logic/dscg_fault_chk.v
// Flags an access strobe aimed at a unit whose clock is gated off.
// One cycle of latency keeps the fault output straight from a flop.
module dscg_fault_chk (
    pclk,
    presetn,
    access_sel,
    clk_en,
    fault_r
);
    input  wire        pclk;
    input  wire        presetn;
    input  wire [31:0] access_sel;
    input  wire [31:0] clk_en;
    output reg         fault_r;

    wire               fault_nxt;

    // Any selected unit without its clock faults the whole access.
    assign fault_nxt = |(access_sel & ~clk_en);

    // Registered fault pulse, cleared at reset.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_r <= 1'b0;
        end else begin
            fault_r <= fault_nxt;
        end
    end
endmodule

// >>> logic/dscg_top.v
`include "dscg_consts.vh"

// Summary of operation
// - each enable bit clocks one peripheral.
// - access to gated unit raises bus fault.
// - reset clears all enables to zero.
// - run, sleep, deep-sleep registers, same layout.
// - sleep registers apply only with auto select.
// - bits 2..0 gate async serial 2..0.
// - reserved bits read zero, ignore writes.
// - deep-sleep register at offset 0x124.
// - bits 26..24 gate comparators 2..0.
// - bits 19..16 gate timers 3..0.
// - bits 12, 8, 4 gate bus, encoder, serial.
module dscg_top (
    pclk,
    presetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata_r,
    pready_r,
    pslverr_r,
    sleep_pin,
    deep_sleep_pin,
    unit_access_sel,
    unit_clk_en_r,
    bus_fault_r,
    irq_r
);
    input  wire        pclk;
    input  wire        presetn;
    input  wire        psel;
    input  wire        penable;
    input  wire        pwrite;
    input  wire [31:0] paddr;
    input  wire [31:0] pwdata;
    output reg  [31:0] prdata_r;
    output reg         pready_r;
    output reg         pslverr_r;
    input  wire        sleep_pin;
    input  wire        deep_sleep_pin;
    input  wire [31:0] unit_access_sel;
    output reg  [31:0] unit_clk_en_r;
    output wire        bus_fault_r;
    output reg         irq_r;

    reg  [31:0] run_clock_gate_1_r;
    reg  [31:0] sleep_clock_gate_1_r;
    reg  [31:0] deep_sleep_clock_gate_1_r;
    reg         auto_clock_gating_select_r;
    reg  [`DSCG_INT_W-1:0] int_status_r;
    reg  [`DSCG_INT_W-1:0] int_mask_r;
    reg  [`DSCG_INT_W-1:0] int_status_nxt;
    reg         deep_prev_r;
    reg  [31:0] rdata_nxt;
    reg         hit_nxt;
    reg  [31:0] unit_clk_en_nxt;

    wire        sleep_lvl;
    wire        deep_lvl;
    wire        setup_ph;
    wire        wr_commit;
    wire        base_hit;
    wire [11:0] ofs;
    wire [31:0] base_word;
    wire [`DSCG_INT_W-1:0] events;

    // Keep only the writable enables; reserved positions stay zero.
    function [31:0] gate_wr;
        input [31:0] wdata;
        begin
            gate_wr = wdata & `DSCG_GATE_WMASK;
        end
    endfunction

    // Pick the gating word for the current power mode.
    function [31:0] gate_sel;
        input        auto_sel;
        input        sleep_m;
        input        deep_m;
        input [31:0] run_g;
        input [31:0] slp_g;
        input [31:0] dsl_g;
        begin
            if (!auto_sel) begin
                gate_sel = run_g;
            end else if (deep_m) begin
                gate_sel = dsl_g;
            end else if (sleep_m) begin
                gate_sel = slp_g;
            end else begin
                gate_sel = run_g;
            end
        end
    endfunction

    // Power-mode levels arrive from the core's pins, not this clock.
    dscg_pin_sync u_sync_sleep (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (sleep_pin),
        .level_r (sleep_lvl)
    );

    dscg_pin_sync u_sync_deep (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (deep_sleep_pin),
        .level_r (deep_lvl)
    );

    dscg_fault_chk u_fault (
        .pclk       (pclk),
        .presetn    (presetn),
        .access_sel (unit_access_sel),
        .clk_en     (unit_clk_en_r),
        .fault_r    (bus_fault_r)
    );

    // The slave answers in the first access cycle, so a transfer always
    // takes exactly two clocks; decode is done in the setup cycle.
    assign setup_ph  = psel & ~penable;
    assign wr_commit = psel & penable & pready_r & pwrite & ~pslverr_r;
    assign ofs       = paddr[11:0];
    // The base is held as a full word so both sides compare equal widths.
    assign base_word = `DSCG_BASE_ADDR;
    assign base_hit  = (paddr[`DSCG_BASE_HI_MSB:`DSCG_BASE_HI_LSB] ==
                        base_word[`DSCG_BASE_HI_MSB:`DSCG_BASE_HI_LSB])
                       && (paddr[1:0] == 2'b00);

    // Read mux and address decode; unmapped words answer with pslverr.
    always @* begin
        rdata_nxt = 32'h0000_0000;
        hit_nxt   = base_hit;
        case (ofs)
            `DSCG_OFS_RUN_GATE: begin
                rdata_nxt = run_clock_gate_1_r;
            end
            `DSCG_OFS_SLEEP_GATE: begin
                rdata_nxt = sleep_clock_gate_1_r;
            end
            `DSCG_OFS_DEEP_GATE: begin
                rdata_nxt = deep_sleep_clock_gate_1_r;
            end
            `DSCG_OFS_RUN_CFG: begin
                rdata_nxt[`DSCG_BIT_AUTO_SEL] = auto_clock_gating_select_r;
            end
            `DSCG_OFS_INT_STATUS: begin
                rdata_nxt[`DSCG_INT_W-1:0] = int_status_r;
            end
            `DSCG_OFS_INT_MASK: begin
                rdata_nxt[`DSCG_INT_W-1:0] = int_mask_r;
            end
            default: begin
                hit_nxt = 1'b0;
            end
        endcase
        if (!hit_nxt) begin
            rdata_nxt = 32'h0000_0000;
        end
    end

    // Bus answer registers: ready for one cycle after each setup.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= setup_ph;
            if (setup_ph) begin
                pslverr_r <= ~hit_nxt;
                prdata_r  <= pwrite ? 32'h0000_0000 : rdata_nxt;
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // Gating and configuration registers.  A write lands only at the
    // edge where the master sees pready, never in the setup cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_clock_gate_1_r         <= `DSCG_GATE_RESET;
            sleep_clock_gate_1_r       <= `DSCG_GATE_RESET;
            deep_sleep_clock_gate_1_r  <= `DSCG_GATE_RESET;
            auto_clock_gating_select_r <= 1'b0;
            int_mask_r                 <= {`DSCG_INT_W{1'b0}};
        end else if (wr_commit) begin
            case (ofs)
                `DSCG_OFS_RUN_GATE: begin
                    run_clock_gate_1_r <= gate_wr(pwdata);
                end
                `DSCG_OFS_SLEEP_GATE: begin
                    sleep_clock_gate_1_r <= gate_wr(pwdata);
                end
                `DSCG_OFS_DEEP_GATE: begin
                    deep_sleep_clock_gate_1_r <= gate_wr(pwdata);
                end
                `DSCG_OFS_RUN_CFG: begin
                    auto_clock_gating_select_r <=
                        pwdata[`DSCG_BIT_AUTO_SEL];
                end
                `DSCG_OFS_INT_MASK: begin
                    int_mask_r <= pwdata[`DSCG_INT_W-1:0];
                end
                default: begin
                    int_mask_r <= int_mask_r;
                end
            endcase
        end
    end

    // Deep-sleep wins over sleep when both mode levels are high.
    always @* begin
        unit_clk_en_nxt = gate_sel(auto_clock_gating_select_r, sleep_lvl,
                                   deep_lvl, run_clock_gate_1_r,
                                   sleep_clock_gate_1_r,
                                   deep_sleep_clock_gate_1_r);
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_clk_en_r <= `DSCG_GATE_RESET;
        end else begin
            unit_clk_en_r <= unit_clk_en_nxt;
        end
    end

    // Deep-sleep entry and exit edges become events alongside the access fault.
    assign events = {deep_prev_r & ~deep_lvl,
                     ~deep_prev_r & deep_lvl,
                     bus_fault_r};

    // Write-one-to-clear status; an event in the clearing cycle survives.
    always @* begin
        int_status_nxt = int_status_r;
        if (wr_commit && (ofs == `DSCG_OFS_INT_STATUS)) begin
            int_status_nxt = int_status_r & ~pwdata[`DSCG_INT_W-1:0];
        end
        int_status_nxt = int_status_nxt | events;
    end

    // Status, edge history and the level interrupt.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status_r <= {`DSCG_INT_W{1'b0}};
            deep_prev_r  <= 1'b0;
            irq_r        <= 1'b0;
        end else begin
            int_status_r <= int_status_nxt;
            deep_prev_r  <= deep_lvl;
            irq_r        <= |(int_status_nxt & int_mask_r);
        end
    end
endmodule

// >>> sim/dscg_chk_assertions.sv
// Watches the gating block from its ports only.
module dscg_chk (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [31:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata_r,
    input logic        pready_r,
    input logic        pslverr_r,
    input logic        sleep_pin,
    input logic        deep_sleep_pin,
    input logic [31:0] unit_access_sel,
    input logic [31:0] unit_clk_en_r,
    input logic        bus_fault_r,
    input logic        irq_r
);
    localparam logic [31:0] WM = 32'h070F_1117;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Steps of a bus access and of a strobe at a gated unit.
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_gated;
        (unit_access_sel & ~unit_clk_en_r) != 32'h0000_0000;
    endsequence

    a_ready_setup:
    assert property (s_setup |=> pready_r) else $error("ready missing");
    a_ready_access:
    assert property (pready_r |-> psel && penable) else $error("stray ready");
    a_unmapped_err:
    assert property (s_setup ##0 paddr[31:12] != 20'h400FE |=> pslverr_r)
        else $error("unmapped access not refused");
    a_err_nodata:
    assert property (pslverr_r |-> prdata_r == 0) else $error("error data");
    a_reserved_zero:
    assert property ((unit_clk_en_r & ~WM) == 0) else $error("reserved set");
    a_fault_gated:
    assert property (s_gated |=> bus_fault_r) else $error("fault missing");
    a_fault_cause:
    assert property (bus_fault_r |-> $past((unit_access_sel
        & ~unit_clk_en_r) != 0)) else $error("fault without cause");
    a_reset_clear:
    assert property ($rose(presetn) |-> unit_clk_en_r == 0 && !irq_r)
        else $error("enables not cleared");
endmodule

bind dscg_top dscg_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
    .sleep_pin(sleep_pin), .deep_sleep_pin(deep_sleep_pin),
    .unit_access_sel(unit_access_sel), .unit_clk_en_r(unit_clk_en_r),
    .bus_fault_r(bus_fault_r), .irq_r(irq_r));

// >>> sim/tb.sv
`include "dscg_consts.vh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] B = `DSCG_BASE_ADDR;
    localparam logic [31:0] WM = 32'h070F_1117;
    logic        pclk = 0;
    logic        presetn = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic        sleep_pin = 0;
    logic        deep_sleep_pin = 0;
    logic        er;
    logic [31:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] unit_access_sel = 0;
    logic [31:0] rd;
    wire  [31:0] prdata_r;
    wire  [31:0] unit_clk_en_r;
    wire         pready_r;
    wire         pslverr_r;
    wire         bus_fault_r;
    wire         irq_r;
    int          failures = 0;
    int          cmp_count = 0;
    int          b;

    dscg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
        .sleep_pin(sleep_pin), .deep_sleep_pin(deep_sleep_pin),
        .unit_access_sel(unit_access_sel), .unit_clk_en_r(unit_clk_en_r),
        .bus_fault_r(bus_fault_r), .irq_r(irq_r));

    // A 50 MHz clock.
    always #10 pclk = ~pclk;

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus transfer; the wait for ready is bounded so a hang ends the run.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // Ready is looked at mid-cycle, where it has settled.
        for (i = 0; i < 16; i++) begin
            @(negedge pclk);
            if (pready_r === 1'b1) break;
            @(posedge pclk);
        end
        rd = prdata_r;
        er = pslverr_r;
        @(posedge pclk);
        psel <= 0;
        penable <= 0;
        if (i == 16) begin
            failures++;
            final_report();
        end
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(rd, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // A one-cycle strobe; returns mid-cycle while the fault pulse stands.
    task automatic strobe(input logic [31:0] s);
        @(posedge pclk);
        unit_access_sel <= s;
        @(posedge pclk);
        unit_access_sel <= 0;
        @(negedge pclk);
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        rdc(B + `DSCG_OFS_DEEP_GATE, 0);
        chk(unit_clk_en_r, 0);
        apb(1, B + `DSCG_OFS_DEEP_GATE, 32'hFFFF_FFFF);
        rdc(B + `DSCG_OFS_DEEP_GATE, WM);
        $display("Test reset and reserved done");
        apb(1, B + `DSCG_OFS_RUN_CFG, 1);
        @(posedge pclk);
        deep_sleep_pin <= 1;
        cyc(8);
        for (b = 0; b < 32; b++) begin
            apb(1, B + `DSCG_OFS_DEEP_GATE, 32'h1 << b);
            rdc(B + `DSCG_OFS_DEEP_GATE, (32'h1 << b) & WM);
            cyc(2);
            chk(unit_clk_en_r, (32'h1 << b) & WM);
        end
        $display("Test bit layout done");
        apb(1, B + `DSCG_OFS_RUN_GATE, 1);
        apb(1, B + `DSCG_OFS_SLEEP_GATE, 2);
        apb(1, B + `DSCG_OFS_DEEP_GATE, 4);
        cyc(2);
        chk(unit_clk_en_r, 4);
        @(posedge pclk);
        deep_sleep_pin <= 0;
        sleep_pin <= 1;
        cyc(8);
        chk(unit_clk_en_r, 2);
        apb(1, B + `DSCG_OFS_RUN_CFG, 0);
        cyc(2);
        chk(unit_clk_en_r, 1);
        $display("Test mode select done");
        apb(1, B + `DSCG_OFS_INT_MASK, 1);
        strobe(32'h4);
        chk(bus_fault_r, 1);
        cyc(3);
        chk(irq_r, 1);
        rdc(B + `DSCG_OFS_INT_STATUS, 32'h0000_0007);
        apb(1, B + `DSCG_OFS_INT_STATUS, 32'hFFFF_FFFF);
        cyc(2);
        chk(irq_r, 0);
        rdc(B + `DSCG_OFS_INT_STATUS, 32'h0000_0000);
        strobe(32'h1);
        chk(bus_fault_r, 0);
        apb(0, B + 32'h200, 0);
        chk({rd[31:1], er}, 1);
        $display("Test fault and refusal done");
        // A second reset in mid-run must clear every enable again.
        @(posedge pclk);
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        rdc(B + `DSCG_OFS_RUN_GATE, 0);
        chk(unit_clk_en_r, 0);
        $display("Test second reset done");
        final_report();
    end
endmodule
